/* File: hdl/fp_unpack_pkg.sv */
// package: operand format constants for the operand unpacker
// assumes: used with package::name, nothing imported
package fp_unpack_pkg;
	// format select codes
	typedef enum logic [1:0] {FMT_SINGLE, FMT_DOUBLE, FMT_EXTENDED, FMT_OTHER} fp_format_t;
	// class codes
	typedef enum logic [2:0] {CLS_ZERO, CLS_DENORMAL, CLS_NORMAL, CLS_INFINITY,
		CLS_QNAN, CLS_SNAN} fp_class_t;
	// packed lane size codes
	typedef enum logic [1:0] {LANE_BYTE, LANE_WORD, LANE_DWORD, LANE_QWORD} lane_size_t;

	localparam int SGL_EXP_W = 8;
	localparam int SGL_FRAC_W = 23;
	localparam int DBL_EXP_W = 11;
	localparam int DBL_FRAC_W = 52;
	localparam int EXT_EXP_W = 15;
	localparam int EXT_FRAC_W = 63;
	localparam int EXT_INT_POS = 63;
	localparam int EXT_FRAC_MSB = 62;
	localparam int SGL_SIGN_POS = 31;
	localparam int DBL_SIGN_POS = 63;
	localparam int EXT_SIGN_POS = 79;
	localparam logic [15:0] SGL_BIAS = 16'd127;
	localparam logic [15:0] DBL_BIAS = 16'd1023;
	localparam logic [15:0] EXT_BIAS = 16'd16383;
	localparam logic [3:0] SGL_BYTES = 4'd4;
	localparam logic [3:0] DBL_BYTES = 4'd8;
	localparam logic [3:0] EXT_BYTES = 4'd10;
	localparam int NEAR_OFS_W = 32;
	localparam int FAR_SEL_W = 16;
	localparam int FAR_PTR_W = 48;
	localparam int FIELD_MAX_LEN = 32;
	localparam logic [32:0] STRING_MAX_BYTES = 33'h0FFFFFFFF;
	localparam int SIMD_NARROW_W = 64;
	localparam int SIMD_WIDE_W = 128;
	localparam logic [79:0] RESET_WORD = 80'h0;
endpackage

/* File: hdl/fp_operand_format_unpacker.sv */
// holds: registered unpacker and classifier for memory operand formats
// assumes: operand word is right aligned, one request per cycle, inputs synchronous
//
// Behaviour
// - single and double store fraction only
// - implied integer bit one except zero/denormal
// - extended integer bit 63, fraction top 62
// - extended integer bit copied from operand bit 63, not from class
// - unbias exponent by 127, 1023, 16383
// - signaling nan has top fraction clear
// - transfer 4, 8 or 10 bytes
// - near pointer is 32-bit offset
// - far pointer selector plus offset, 48 bits
// - bit field start 0 to 31, up to 32
// - strings up to 4 GBytes, any bit
// - packed operands 64 or 128 bits
// - 64-bit operand into independent lanes
module fp_operand_format_unpacker #(
	parameter int FIELD_LEN_W = 6
)(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_valid,
	input wire logic [79:0] i_operand,
	input wire logic [1:0] i_format,
	input wire logic [127:0] i_simd_operand,
	input wire logic i_simd_wide,
	input wire logic [1:0] i_lane_size,
	input wire logic [4:0] i_field_start,
	input wire logic [FIELD_LEN_W-1:0] i_field_len,
	input wire logic [32:0] i_string_len,
	output logic o_valid,
	output logic o_sign,
	output logic [15:0] o_biased_exp,
	output logic signed [16:0] o_unbiased_exp,
	output logic o_integer_bit,
	output logic [62:0] o_fraction,
	output logic [2:0] o_class,
	output logic [3:0] o_byte_count,
	output logic [79:0] o_default_nan,
	output logic [31:0] o_near_offset,
	output logic [15:0] o_far_selector,
	output logic [31:0] o_far_offset,
	output logic [31:0] o_field_value,
	output logic o_field_error,
	output logic o_string_error,
	output logic [127:0] o_simd_lanes,
	output logic o_simd_error
);
	if (FIELD_LEN_W < 6 || FIELD_LEN_W > 8)
	begin
		$error("FIELD_LEN_W must be 6 to 8");
	end

	// ****************************************
	// field split helpers
	// ****************************************
	function automatic fp_unpack_pkg::fp_class_t classify(input logic exp_zero,
		input logic exp_ones, input logic frac_zero, input logic frac_top);
		fp_unpack_pkg::fp_class_t c;
		c = fp_unpack_pkg::CLS_NORMAL;
		if (exp_zero)
			c = frac_zero ? fp_unpack_pkg::CLS_ZERO : fp_unpack_pkg::CLS_DENORMAL;
		else if (exp_ones)
		begin
			if (frac_zero)
				c = fp_unpack_pkg::CLS_INFINITY;
			else if (frac_top)
				c = fp_unpack_pkg::CLS_QNAN;
			else
				c = fp_unpack_pkg::CLS_SNAN;
		end
		return c;
	endfunction

	function automatic logic [31:0] lane_mask(input logic [5:0] len);
		logic [31:0] m;
		m = 32'hFFFFFFFF;
		if (len < 6'h20)
			m = ~(32'hFFFFFFFF << len[4:0]);
		return m;
	endfunction

	// ****************************************
	// format decode
	// ****************************************
	logic sign_w;
	logic [15:0] exp_w;
	logic [62:0] frac_w;
	logic ext_int_w;
	logic exp_zero_w;
	logic exp_ones_w;
	logic frac_top_w;
	logic [15:0] bias_w;
	logic [3:0] bytes_w;
	fp_unpack_pkg::fp_class_t class_w;

	always_comb
	begin
		sign_w = 1'b0;
		exp_w = 16'h0000;
		frac_w = 63'h0;
		ext_int_w = 1'b0;
		exp_zero_w = 1'b0;
		exp_ones_w = 1'b0;
		frac_top_w = 1'b0;
		bias_w = fp_unpack_pkg::SGL_BIAS;
		bytes_w = fp_unpack_pkg::SGL_BYTES;
		unique case (fp_unpack_pkg::fp_format_t'(i_format))
			fp_unpack_pkg::FMT_SINGLE:
			begin
				sign_w = i_operand[fp_unpack_pkg::SGL_SIGN_POS];
				exp_w = {8'h00, i_operand[30:23]};
				frac_w = {i_operand[22:0], 40'h0};
				exp_zero_w = (i_operand[30:23] == 8'h00);
				exp_ones_w = (i_operand[30:23] == 8'hFF);
				bias_w = fp_unpack_pkg::SGL_BIAS;
				bytes_w = fp_unpack_pkg::SGL_BYTES;
			end
			fp_unpack_pkg::FMT_DOUBLE:
			begin
				sign_w = i_operand[fp_unpack_pkg::DBL_SIGN_POS];
				exp_w = {5'h00, i_operand[62:52]};
				frac_w = {i_operand[51:0], 11'h0};
				exp_zero_w = (i_operand[62:52] == 11'h000);
				exp_ones_w = (i_operand[62:52] == 11'h7FF);
				bias_w = fp_unpack_pkg::DBL_BIAS;
				bytes_w = fp_unpack_pkg::DBL_BYTES;
			end
			fp_unpack_pkg::FMT_EXTENDED:
			begin
				sign_w = i_operand[fp_unpack_pkg::EXT_SIGN_POS];
				exp_w = {1'b0, i_operand[78:64]};
				ext_int_w = i_operand[fp_unpack_pkg::EXT_INT_POS];
				frac_w = i_operand[fp_unpack_pkg::EXT_FRAC_MSB:0];
				exp_zero_w = (i_operand[78:64] == 15'h0000);
				exp_ones_w = (i_operand[78:64] == 15'h7FFF);
				bias_w = fp_unpack_pkg::EXT_BIAS;
				bytes_w = fp_unpack_pkg::EXT_BYTES;
			end
			default:
			begin
				exp_zero_w = 1'b1;
			end
		endcase
		frac_top_w = frac_w[62];
		class_w = classify(exp_zero_w, exp_ones_w, frac_w == 63'h0, frac_top_w);
	end

	// ****************************************
	// float outputs
	// ****************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_valid <= 1'b0;
			o_sign <= 1'b0;
			o_biased_exp <= 16'h0000;
			o_unbiased_exp <= 17'h00000;
			o_integer_bit <= 1'b0;
			o_fraction <= 63'h0;
			o_class <= 3'h0;
			o_byte_count <= 4'h0;
			o_default_nan <= fp_unpack_pkg::RESET_WORD;
		end
		else
		begin
			o_valid <= i_valid;
			if (i_valid)
			begin
				o_sign <= sign_w;
				o_biased_exp <= exp_w;
				o_unbiased_exp <= $signed({1'b0, exp_w}) - $signed({1'b0, bias_w});
				o_integer_bit <= (i_format == 2'(fp_unpack_pkg::FMT_EXTENDED)) ? ext_int_w
					: !exp_zero_w;
				o_fraction <= frac_w;
				o_class <= 3'(class_w);
				o_byte_count <= bytes_w;
				unique case (fp_unpack_pkg::fp_format_t'(i_format))
					fp_unpack_pkg::FMT_SINGLE: o_default_nan <= {48'h0, 32'hFFC00000};
					fp_unpack_pkg::FMT_DOUBLE: o_default_nan <= {16'h0, 64'hFFF8000000000000};
					fp_unpack_pkg::FMT_EXTENDED: o_default_nan <= 80'hFFFFC000000000000000;
					default: o_default_nan <= fp_unpack_pkg::RESET_WORD;
				endcase
			end
		end
	end

	// ****************************************
	// pointers, fields, strings
	// ****************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_near_offset <= 32'h0;
			o_far_selector <= 16'h0;
			o_far_offset <= 32'h0;
			o_field_value <= 32'h0;
			o_field_error <= 1'b0;
			o_string_error <= 1'b0;
		end
		else if (i_valid)
		begin
			o_near_offset <= i_operand[fp_unpack_pkg::NEAR_OFS_W-1:0];
			o_far_offset <= i_operand[31:0];
			o_far_selector <= i_operand[fp_unpack_pkg::FAR_PTR_W-1:32];
			o_field_value <= 32'(i_operand[63:0] >> i_field_start) & lane_mask(6'(i_field_len));
			o_field_error <= (i_field_len > FIELD_LEN_W'(fp_unpack_pkg::FIELD_MAX_LEN));
			o_string_error <= (i_string_len > fp_unpack_pkg::STRING_MAX_BYTES);
		end
	end

	// ****************************************
	// packed lanes
	// ****************************************
	always_ff @(posedge i_mclk)
	begin
		if (i_reset)
		begin
			o_simd_lanes <= 128'h0;
			o_simd_error <= 1'b0;
		end
		else if (i_valid)
		begin
			o_simd_lanes <= i_simd_wide ? i_simd_operand : {64'h0, i_simd_operand[63:0]};
			o_simd_error <= !i_simd_wide && (i_lane_size == 2'(fp_unpack_pkg::LANE_QWORD));
		end
	end
endmodule

/* File: testbench/fp_unpacker_props.sv */
// holds: timing and field checks of the operand unpacker
// assumes: bound to the top unpacker, one clock, sync reset
module fp_unpacker_props (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_valid,
	input wire logic [79:0] i_operand,
	input wire logic [1:0] i_format,
	input wire logic o_valid,
	input wire logic o_integer_bit,
	input wire logic signed [16:0] o_unbiased_exp,
	input wire logic [3:0] o_byte_count,
	input wire logic [2:0] o_class,
	input wire logic [15:0] o_far_selector,
	input wire logic [31:0] o_far_offset
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	a_answer_next: assert property (i_valid |=> o_valid)
		else $error("answer missing");
	a_outputs_hold: assert property (!i_valid |=> !o_valid && $stable(o_class))
		else $error("outputs moved without request");
	a_single_int_bit:
	assert property (i_valid && i_format == 2'h0 |=>
		o_integer_bit == ($past(i_operand[30:23]) != 8'h00)) else $error("single integer bit");
	a_ext_int_bit:
	assert property (i_valid && i_format == 2'h2 |=> o_integer_bit == $past(i_operand[63]))
		else $error("extended integer bit");
	a_single_bias:
	assert property (i_valid && i_format == 2'h0 |=>
		o_unbiased_exp + 17'h7F == 17'($past(i_operand[30:23]))) else $error("single bias");
	a_ext_bias:
	assert property (i_valid && i_format == 2'h2 |=>
		o_unbiased_exp + 17'h3FFF == 17'($past(i_operand[78:64]))) else $error("extended bias");
	a_byte_len:
	assert property (i_valid |=> o_byte_count == ($past(i_format) == 2'h1 ? 4'h8 :
		$past(i_format) == 2'h2 ? 4'hA : 4'h4)) else $error("byte count");
	a_snan_flag:
	assert property (i_valid && i_format == 2'h0 && i_operand[30:22] == 9'h1FE &&
		i_operand[21:0] != 22'h0 |=> o_class == 3'h5) else $error("signaling nan");
	a_qnan_flag:
	assert property (i_valid && i_format == 2'h0 && i_operand[30:22] == 9'h1FF |=>
		o_class == 3'h4) else $error("quiet nan");
	a_far_split:
	assert property (i_valid |=> {o_far_selector, o_far_offset} == $past(i_operand[47:0]))
		else $error("far pointer split");
endmodule

bind fp_operand_format_unpacker fp_unpacker_props u_props (.i_mclk, .i_reset, .i_valid,
	.i_operand, .i_format, .o_valid, .o_integer_bit, .o_unbiased_exp, .o_byte_count,
	.o_class, .o_far_selector, .o_far_offset);

/* File: testbench/fp_operand_format_unpacker_test.sv */
// holds: self-checking bench for the operand unpacker
// assumes: checker bound separately, inputs driven on falling edge
module fp_operand_format_unpacker_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 0, i_reset = 1, i_valid = 0, i_simd_wide = 0;
	logic [79:0] i_operand = 80'h0;
	logic [1:0] i_format = 2'h0, i_lane_size = 2'h0;
	logic [127:0] i_simd_operand = 128'h0;
	logic [4:0] i_field_start = 5'h0;
	logic [5:0] i_field_len = 6'h0;
	logic [32:0] i_string_len = 33'h0;
	logic o_valid, o_sign, o_integer_bit, o_field_error, o_string_error, o_simd_error;
	logic [15:0] o_biased_exp, o_far_selector;
	logic signed [16:0] o_unbiased_exp;
	logic [62:0] o_fraction;
	logic [2:0] o_class;
	logic [3:0] o_byte_count;
	logic [79:0] o_default_nan;
	logic [31:0] o_near_offset, o_far_offset, o_field_value;
	logic [127:0] o_simd_lanes;
	int errors = 0, compares = 0;
	fp_operand_format_unpacker dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_valid(i_valid),
		.i_operand(i_operand), .i_format(i_format), .i_simd_operand(i_simd_operand),
		.i_simd_wide(i_simd_wide), .i_lane_size(i_lane_size), .i_field_start(i_field_start),
		.i_field_len(i_field_len), .i_string_len(i_string_len), .o_valid(o_valid),
		.o_sign(o_sign), .o_biased_exp(o_biased_exp), .o_unbiased_exp(o_unbiased_exp),
		.o_integer_bit(o_integer_bit), .o_fraction(o_fraction), .o_class(o_class),
		.o_byte_count(o_byte_count), .o_default_nan(o_default_nan),
		.o_near_offset(o_near_offset), .o_far_selector(o_far_selector),
		.o_far_offset(o_far_offset), .o_field_value(o_field_value),
		.o_field_error(o_field_error), .o_string_error(o_string_error),
		.o_simd_lanes(o_simd_lanes), .o_simd_error(o_simd_error));
	// ****************
	// helpers
	// ****************
	initial forever #12.5 i_mclk = ~i_mclk;
	task chk(input string n, input logic [127:0] e, input logic [127:0] g);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task go;
		@(negedge i_mclk) i_valid = 1;
		@(negedge i_mclk) i_valid = 0;
	endtask
	task results;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task t_single;
		i_operand = 80'h43322000;
		go;
		chk("valid", 'h1, o_valid);
		chk("bexp", 'h86, o_biased_exp);
		chk("sdnan", 'hFFC00000, o_default_nan);
		chk("uexp", 'h7, o_unbiased_exp);
		chk("frac", 'h3220000000000000, o_fraction);
		chk("class", 'h2, o_class);
		chk("bytes", 'h4, o_byte_count);
		i_operand = 80'h80000001;
		go;
		chk("denorm", 'h1, o_class);
		chk("intb", 'h0, o_integer_bit);
		chk("sign", 'h1, o_sign);
	endtask
	task t_double;
		i_format = 2'h1;
		i_operand = 80'hFFF0000000000000;
		go;
		chk("inf", 'h3, o_class);
		chk("uexp", 'h400, o_unbiased_exp);
		chk("bytes", 'h8, o_byte_count);
		chk("dnan", 'hFFF8000000000000, o_default_nan);
	endtask
	task t_nan;
		i_format = 2'h0;
		i_operand = 80'h7FA00000;
		go;
		chk("snan", 'h5, o_class);
		i_operand = 80'h7FC00000;
		go;
		chk("qnan", 'h4, o_class);
		i_format = 2'h2;
		i_operand = 80'hFFFFA000000000000000;
		go;
		chk("xsnan", 'h5, o_class);
		chk("xdnan", 'hFFFFC000000000000000, o_default_nan);
		i_operand = 80'h3FFF8000000000000000;
		go;
		chk("xint", 'h1, o_integer_bit);
		chk("xuexp", 'h0, o_unbiased_exp);
		chk("xbytes", 'hA, o_byte_count);
		i_operand = 80'h00000000000000000001;
		go;
		chk("xden", 'h1, o_class);
		chk("xint0", 'h0, o_integer_bit);
	endtask
	task t_misc;
		i_format = 2'h3;
		i_operand = 80'h8000000180000000;
		i_field_start = 5'h1F;
		i_field_len = 6'h20;
		i_string_len = 33'h0FFFFFFFF;
		i_simd_operand = 128'h0123456789ABCDEFFEDCBA9876543210;
		i_lane_size = 2'h3;
		go;
		chk("near", 'h80000000, o_near_offset);
		chk("sel", 'h0001, o_far_selector);
		chk("field", 'h3, o_field_value);
		chk("ferr", 'h0, o_field_error);
		chk("serr", 'h0, o_string_error);
		chk("lanes", 'hFEDCBA9876543210, o_simd_lanes);
		chk("qerr", 'h1, o_simd_error);
		i_field_len = 6'h21;
		i_string_len = 33'h100000000;
		i_simd_wide = 1;
		go;
		chk("ferr2", 'h1, o_field_error);
		chk("serr2", 'h1, o_string_error);
		chk("wide", 128'h0123456789ABCDEFFEDCBA9876543210, o_simd_lanes);
		chk("qerr2", 'h0, o_simd_error);
	endtask
	initial
	begin
		#20000;
		errors++;
		results;
	end
	initial
	begin
		repeat (20) @(negedge i_mclk);
		i_reset = 0;
		t_single;
		t_double;
		t_nan;
		t_misc;
		results;
	end
endmodule
